// >>> inc/adc_seq_pkg.sv
/*
 Constants, encodings and state type shared by the conversion sequencer
 and its testbench. Assumes a 20 MHz system clock.
*/
package adc_seq_pkg;

	// System clock and start-up timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int OSC_START_NS  = 125;
	localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_DIV_DEF   = 5;

	// Command register layout
	localparam int CMD_BITS    = 8;
	localparam int CMD_CH_HI   = 7;
	localparam int CMD_CH_LO   = 5;
	localparam int CMD_SCAN_HI = 4;
	localparam int CMD_SCAN_LO = 3;
	localparam int CMD_PD_HI   = 2;
	localparam int CMD_PD_LO   = 1;
	localparam int CMD_CLK_BIT = 0;
	localparam int CH_W        = CMD_CH_HI - CMD_CH_LO + 1;

	// Serial edge counts, internal clock modes
	localparam int CHAN_SEL_EDGE = 3;
	localparam int CMD_EDGES_8   = 8;
	localparam int CMD_EDGES_16  = 16;

	// Internal oscillator cycle marks
	localparam int ACQ_START_OSC  = 2;
	localparam int ACQ_END_OSC_8  = 6;
	localparam int ACQ_END_OSC_16 = 18;
	localparam int OSC_TOTAL_8    = 25;
	localparam int OSC_TOTAL_16   = 32;

	// Frame-sync transfer edge marks
	localparam int DSP_CMD_EDGES   = 8;
	localparam int DSP_SEL_EDGE    = 3;
	localparam int DSP_SAMPLE_EDGE = 7;
	localparam int DSP_FSO_EDGE    = 8;
	localparam int DSP_DATA_EDGE   = 9;

	// Result word, power-down reset and scan settings
	localparam int              RESULT_BITS = 16;
	localparam logic [15:0]     RESULT_MSB  = 16'h8000;
	localparam logic [1:0]      PD_RESET    = 2'h0;
	localparam logic [CH_W-1:0] SCAN_CH_FROM = 3'h2;
	localparam logic [2:0]      REPEAT_LEFT  = 3'h3;

	typedef enum logic [1:0] {
		SCAN_SINGLE = 2'h0,
		SCAN_UP     = 2'h1,
		SCAN_FROM2  = 2'h2,
		SCAN_REPEAT = 2'h3
	} scan_e;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_CMD      = 3'h1,
		ST_START    = 3'h3,
		ST_CONV     = 3'h2,
		ST_READ     = 3'h6,
		ST_DSP_WAIT = 3'h7,
		ST_DSP_XFER = 3'h5
	} state_e;

endpackage

// >>> rtl/result_fifo.sv
/*
 Result buffer: synchronous FIFO with a registered output word.
 Assumes one clock domain; flush empties it in one cycle.
*/
`timescale 1ns/1ns
module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
		logic                        ov;
		logic [WIDTH-1:0]            od;
	} fifo_s;

	fifo_s r;
	fifo_s n;
	logic  push;
	logic  take;

	always_comb begin
		n = r;
		in_ready = (r.cnt != (AW+1)'(DEPTH));
		push = in_valid && in_ready;
		take = (r.cnt != '0) && (!r.ov || out_ready);
		if (out_ready && r.ov) begin
			n.ov = 1'b0;
		end
		if (take) begin
			n.od = r.mem[r.rp];
			n.ov = 1'b1;
			n.rp = r.rp + 1'b1;
		end
		if (push) begin
			n.mem[r.wp] = in_data;
			n.wp = r.wp + 1'b1;
		end
		n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(take);
		if (flush) begin
			n.wp = '0;
			n.rp = '0;
			n.cnt = '0;
			n.ov = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign out_valid = r.ov;
	assign out_data = r.od;
endmodule

// >>> rtl/conv_sequencer.sv
/*
 Serial command interface and conversion sequencer of a multichannel
 16-bit successive-approximation converter: internal-clock 8/16-bit
 transfer with scan, and frame-sync 8-bit transfer.
 Assumes the serial link pins are asynchronous to CLK and that the serial clock runs
 well below CLK/4. The analog core supplies one comparator decision per
 trial code.
*/
`timescale 1ns/1ns
module conv_sequencer
	import adc_seq_pkg::*;
#(
	parameter int OSC_DIV    = adc_seq_pkg::OSC_DIV_DEF,
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input  wire logic                          CLK,
	input  wire logic                          RST_N,
	// Serial link pins
	input  wire logic                          CS_N,
	input  wire logic                          SCLK,
	input  wire logic                          DIN,
	input  wire logic                          FRAME_SYNC_IN,
	input  wire logic                          WORD_WIDTH_SELECT,
	output logic                               DOUT,
	output logic                               DOUT_OE,
	output logic                               EOC_N,
	output logic                               FRAME_SYNC_OUT,
	// Converter core
	input  wire logic                          CMP_HIGH,
	output logic                               ANALOG_WAKE,
	output logic                               OSC_RUN,
	output logic [adc_seq_pkg::CH_W-1:0]       CHANNEL,
	output logic                               ACQUIRE,
	output logic                               SAMPLE,
	output logic [adc_seq_pkg::RESULT_BITS-1:0] SAR_TRIAL,
	// Status
	output logic [1:0]                         PD_MODE,
	output logic                               DSP_MODE
);
	import adc_seq_pkg::*;

	localparam int DW = $clog2(OSC_DIV);

	typedef struct packed {
		logic                   cs_m, cs_q, cs_d;
		logic                   ck_m, ck_q, ck_d;
		logic                   di_m, di_q;
		logic                   fs_m, fs_q, fs_d;
		logic                   ws_m, ws_q;
		state_e                 st;
		logic                   dsp;
		logic                   wide;
		logic [CMD_BITS-1:0]    cmd;
		logic [4:0]             edge_cnt;
		logic [4:0]             rise_cnt;
		logic [2:0]             wait_cnt;
		logic [DW-1:0]          osc_div;
		logic [5:0]             osc_cyc;
		logic [RESULT_BITS-1:0] trial;
		logic [RESULT_BITS-1:0] mask;
		logic                   sar_run;
		logic                   sampled;
		logic                   last_done;
		logic [CH_W-1:0]        ch;
		logic [2:0]             left;
		scan_e                  scan;
		logic [RESULT_BITS-1:0] shreg;
		logic [3:0]             out_idx;
		logic                   dout, dout_oe, eoc_n, fso, wake, osc_run, acq, smp;
		logic [1:0]             pd;
	} seq_s;

	seq_s                   r;
	seq_s                   n;
	logic                   fifo_in_valid;
	logic                   fifo_in_ready;
	logic [RESULT_BITS-1:0] fifo_in_data;
	logic                   fifo_out_valid;
	logic                   fifo_out_ready;
	logic [RESULT_BITS-1:0] fifo_out_data;
	logic                   fifo_flush;

	always_comb begin
		logic                   cs_rise, cs_fall, ck_rise, ck_fall, fs_rise, fs_fall;
		logic                   osc_rise, osc_fall;
		logic [RESULT_BITS-1:0] t;
		logic [RESULT_BITS-1:0] nm;
		logic [4:0]             e;
		logic [5:0]             acq_end, total;
		logic [CH_W-1:0]        top_ch;
		int                     idx;
		cs_rise = r.cs_q && !r.cs_d;
		cs_fall = !r.cs_q && r.cs_d;
		ck_rise = r.ck_q && !r.ck_d;
		ck_fall = !r.ck_q && r.ck_d;
		fs_rise = r.fs_q && !r.fs_d;
		fs_fall = !r.fs_q && r.fs_d;
		osc_rise = r.osc_run && (r.osc_div == '0);
		osc_fall = r.osc_run && (r.osc_div == DW'(OSC_DIV / 2));
		t = r.trial;
		nm = r.mask;
		e = r.edge_cnt;
		acq_end = r.wide ? 6'(ACQ_END_OSC_16) : 6'(ACQ_END_OSC_8);
		total = r.wide ? 6'(OSC_TOTAL_16) : 6'(OSC_TOTAL_8);
		top_ch = r.cmd[CMD_CH_HI:CMD_CH_LO];
		idx = 0;
		n = r;
		fifo_in_valid = 1'b0;
		fifo_in_data = r.trial;
		fifo_out_ready = 1'b0;
		fifo_flush = 1'b0;

		// Two-stage pin synchronisers
		n.cs_m = CS_N;
		n.cs_q = r.cs_m;
		n.cs_d = r.cs_q;
		n.ck_m = SCLK;
		n.ck_q = r.ck_m;
		n.ck_d = r.ck_q;
		n.di_m = DIN;
		n.di_q = r.di_m;
		n.fs_m = FRAME_SYNC_IN;
		n.fs_q = r.fs_m;
		n.fs_d = r.fs_q;
		n.ws_m = WORD_WIDTH_SELECT;
		n.ws_q = r.ws_m;
		n.smp = 1'b0;

		// Internal oscillator from the system clock
		if (r.osc_run) begin
			n.osc_div = (r.osc_div == DW'(OSC_DIV - 1)) ? '0 : r.osc_div + 1'b1;
		end

		if (r.sar_run && (r.dsp || osc_rise)) begin
			if (!CMP_HIGH) begin
				t = r.trial & ~r.mask;
			end
			nm = r.mask >> 1;
			n.trial = t | nm;
			n.mask = nm;
			n.sar_run = (nm != '0);
		end

		case (r.st)
			ST_IDLE: begin
				// frame mode picked at select fall
				if (cs_fall && !r.fs_q) begin
					n.st = ST_DSP_WAIT;
					n.dsp = 1'b1;
					n.dout_oe = 1'b1;
					n.dout = 1'b0;
				end else if (cs_fall) begin
					n.st = ST_CMD;
					n.dsp = 1'b0;
					n.wide = r.ws_q;
					n.wake = 1'b1;
					n.dout_oe = 1'b1;
					n.dout = 1'b0;
					n.edge_cnt = '0;
					fifo_flush = 1'b1;
				end
			end
			ST_CMD: begin
				if (ck_rise) begin
					e = r.edge_cnt + 1'b1;
					n.edge_cnt = e;
					if (e <= 5'(CMD_BITS)) begin
						n.cmd = {r.cmd[CMD_BITS-2:0], r.di_q};
					end
					if (e == 5'(CHAN_SEL_EDGE)) begin
						n.ch = {r.cmd[CHAN_SEL_EDGE-2:0], r.di_q};
					end
					// start count after last command edge
					if (e == (r.wide ? 5'(CMD_EDGES_16) : 5'(CMD_EDGES_8))) begin
						n.st = ST_START;
						n.wait_cnt = '0;
					end
				end
			end
			ST_START: begin
				n.wait_cnt = r.wait_cnt + 1'b1;
				if (r.wait_cnt == 3'(OSC_START_CYC - 1)) begin
					n.st = ST_CONV;
					n.osc_run = 1'b1;
					n.osc_div = '0;
					n.osc_cyc = '0;
					n.sampled = 1'b0;
					n.last_done = 1'b0;
					n.scan = scan_e'(r.cmd[CMD_SCAN_HI:CMD_SCAN_LO]);
					case (scan_e'(r.cmd[CMD_SCAN_HI:CMD_SCAN_LO]))
						SCAN_UP: begin
							n.ch = '0;
							n.left = 3'(top_ch);
						end
						SCAN_FROM2: begin
							n.ch = (top_ch > SCAN_CH_FROM) ? SCAN_CH_FROM : top_ch;
							n.left = (top_ch > SCAN_CH_FROM) ? 3'(top_ch - SCAN_CH_FROM) : 3'h0;
						end
						SCAN_REPEAT: begin
							n.left = REPEAT_LEFT;
						end
						default: begin
							n.left = 3'h0;
						end
					endcase
				end
			end
			ST_CONV: begin
				if (osc_rise && (r.osc_cyc != 6'h3f)) begin
					n.osc_cyc = r.osc_cyc + 1'b1;
					if (r.osc_cyc + 1'b1 == 6'(ACQ_START_OSC) && !r.sampled) begin
						n.acq = 1'b1;
					end
				end
				if (osc_fall && r.acq && r.osc_cyc == acq_end) begin
					n.acq = 1'b0;
					n.smp = 1'b1;
					n.sampled = 1'b1;
					n.sar_run = 1'b1;
					n.trial = RESULT_MSB;
					n.mask = RESULT_MSB;
				end
				// conversion closes at full oscillator count
				if (r.sampled && !r.sar_run && r.osc_cyc >= total && !r.last_done) begin
					fifo_in_valid = 1'b1;
					if (fifo_in_ready) begin
						n.sampled = 1'b0;
						n.osc_cyc = '0;
						if (r.left != '0) begin
							n.left = r.left - 1'b1;
							n.ch = (r.scan == SCAN_REPEAT) ? r.ch : r.ch + 1'b1;
						end else begin
							n.last_done = 1'b1;
						end
					end
				end
				if (r.last_done && fifo_out_valid) begin
					n.st = ST_READ;
					n.eoc_n = 1'b0;
					n.osc_run = 1'b0;
					n.wake = 1'b0;
					n.shreg = fifo_out_data;
					n.dout = fifo_out_data[RESULT_BITS-1];
					n.out_idx = '0;
					fifo_out_ready = 1'b1;
					fifo_in_valid = 1'b1;
					fifo_in_data = fifo_out_data;
				end
			end
			ST_READ: begin
				if (ck_fall) begin
					// words recirculate so extra clocks repeat them
					if (r.out_idx == 4'(RESULT_BITS - 1)) begin
						n.out_idx = '0;
						n.shreg = fifo_out_data;
						n.dout = fifo_out_data[RESULT_BITS-1];
						fifo_out_ready = 1'b1;
						fifo_in_valid = fifo_out_valid;
						fifo_in_data = fifo_out_data;
					end else begin
						n.out_idx = r.out_idx + 1'b1;
						n.shreg = {r.shreg[RESULT_BITS-2:0], 1'b0};
						n.dout = r.shreg[RESULT_BITS-2];
					end
				end
			end
			ST_DSP_WAIT: begin
				if (fs_fall) begin
					n.st = ST_DSP_XFER;
					n.edge_cnt = '0;
					n.rise_cnt = '0;
				end
			end
			ST_DSP_XFER: begin
				if (ck_fall && r.edge_cnt != 5'h1f) begin
					e = r.edge_cnt + 1'b1;
					n.edge_cnt = e;
					if (e <= 5'(DSP_CMD_EDGES)) begin
						n.cmd = {r.cmd[CMD_BITS-2:0], r.di_q};
					end
					// channel and acquisition at fall three
					if (e == 5'(DSP_SEL_EDGE)) begin
						n.ch = {r.cmd[DSP_SEL_EDGE-2:0], r.di_q};
						n.acq = 1'b1;
					end
				end
				if (ck_rise && r.rise_cnt != 5'h1f) begin
					e = r.rise_cnt + 1'b1;
					n.rise_cnt = e;
					if (e == 5'(DSP_SAMPLE_EDGE)) begin
						n.acq = 1'b0;
						n.smp = 1'b1;
						n.sar_run = 1'b1;
						n.trial = RESULT_MSB;
						n.mask = RESULT_MSB;
					end
					n.fso = (e == 5'(DSP_FSO_EDGE));
					if (e >= 5'(DSP_DATA_EDGE) && e < 5'(DSP_DATA_EDGE + RESULT_BITS)) begin
						idx = RESULT_BITS - 1 - (int'(e) - DSP_DATA_EDGE);
						n.dout = r.trial[idx];
					end else begin
						n.dout = 1'b0;
					end
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		// new frame strobe restarts the conversion
		if (r.dsp && fs_rise && r.st != ST_IDLE) begin
			n.st = ST_DSP_WAIT;
			n.wake = 1'b1;
			n.acq = 1'b0;
			n.sar_run = 1'b0;
			n.fso = 1'b0;
			n.dout = 1'b0;
		end

		if (cs_rise) begin
			n.st = ST_IDLE;
			n.dsp = 1'b0;
			n.wake = 1'b0;
			n.osc_run = 1'b0;
			n.acq = 1'b0;
			n.sar_run = 1'b0;
			n.fso = 1'b0;
			n.eoc_n = 1'b1;
			n.dout_oe = 1'b0;
			n.dout = 1'b0;
			n.pd = r.cmd[CMD_PD_HI:CMD_PD_LO];
			fifo_flush = 1'b1;
			fifo_in_valid = 1'b0;
			fifo_out_ready = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			r <= '0;
			r.cs_m <= 1'b1;
			r.cs_q <= 1'b1;
			r.cs_d <= 1'b1;
			r.fs_m <= 1'b1;
			r.fs_q <= 1'b1;
			r.fs_d <= 1'b1;
			r.st <= ST_IDLE;
			r.scan <= SCAN_SINGLE;
			r.eoc_n <= 1'b1;
			r.pd <= PD_RESET;
		end else begin
			r <= n;
		end
	end

	result_fifo #(
		.WIDTH(RESULT_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_results (
		.clk      (CLK),
		.rst_n    (RST_N),
		.flush    (fifo_flush),
		.in_valid (fifo_in_valid),
		.in_ready (fifo_in_ready),
		.in_data  (fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data (fifo_out_data)
	);

	assign DOUT = r.dout;
	assign DOUT_OE = r.dout_oe;
	assign EOC_N = r.eoc_n;
	assign FRAME_SYNC_OUT = r.fso;
	assign ANALOG_WAKE = r.wake;
	assign OSC_RUN = r.osc_run;
	assign CHANNEL = r.ch;
	assign ACQUIRE = r.acq;
	assign SAMPLE = r.smp;
	assign SAR_TRIAL = r.trial;
	assign PD_MODE = r.pd;
	assign DSP_MODE = r.dsp;
endmodule

// >>> testbench/conv_sequencer_props.sv
/*
 Port checker for conv_sequencer, bound to every instance.
 Assumes pins move at falling CLK edges and are seen three CLK later.
*/
`timescale 1ns/1ns
module conv_sequencer_props (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Pins
	input wire logic CS_N,
	input wire logic DOUT,
	input wire logic DOUT_OE,
	input wire logic EOC_N,
	input wire logic FRAME_SYNC_OUT,
	// Core and status
	input wire logic ANALOG_WAKE,
	input wire logic OSC_RUN,
	input wire logic ACQUIRE,
	input wire logic SAMPLE,
	input wire logic DSP_MODE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_sel_low;
		!CS_N [*4];
	endsequence
	sequence s_fso_hold;
		FRAME_SYNC_OUT [*7];
	endsequence

	AST_SEL_WAKE: assert property ($fell(CS_N) ##1 !CS_N [*4] |-> DOUT_OE && (DSP_MODE || (ANALOG_WAKE && !DOUT)))
		else $error("output not driven low after select fall");
	AST_DESEL_RELEASE: assert property (CS_N [*5] |-> !DOUT_OE && EOC_N)
		else $error("output still driven while deselected");
	AST_DESEL_SHUTDOWN: assert property (CS_N [*5] |-> !OSC_RUN && !ANALOG_WAKE)
		else $error("converter awake while deselected");
	AST_EOC_SHUTDOWN: assert property ($fell(EOC_N) |-> !OSC_RUN && !ANALOG_WAKE && DOUT_OE && !DSP_MODE)
		else $error("end of conversion without shutdown");
	AST_EOC_HOLD: assert property (s_sel_low ##0 !EOC_N |=> !EOC_N)
		else $error("end of conversion released while selected");
	AST_OSC_QUIET: assert property (!EOC_N |-> !OSC_RUN)
		else $error("oscillator running while results shown");
	AST_SAMPLE_ENDS_ACQ: assert property (SAMPLE |-> $fell(ACQUIRE) ##1 !SAMPLE)
		else $error("sample strobe not at end of acquisition");
	AST_ACQ_AWAKE: assert property (ACQUIRE |-> ANALOG_WAKE)
		else $error("acquisition while analog side asleep");
	AST_FSO_WIDTH: assert property ($rose(FRAME_SYNC_OUT) |-> s_fso_hold ##[1:4] !FRAME_SYNC_OUT)
		else $error("frame sync out not one serial period");
	AST_FSO_DSP_ONLY: assert property (FRAME_SYNC_OUT |-> DSP_MODE && DOUT_OE)
		else $error("frame sync out outside frame mode");
endmodule

bind conv_sequencer conv_sequencer_props i_props (
	.CLK            (CLK),
	.RST_N          (RST_N),
	.CS_N           (CS_N),
	.DOUT           (DOUT),
	.DOUT_OE        (DOUT_OE),
	.EOC_N          (EOC_N),
	.FRAME_SYNC_OUT (FRAME_SYNC_OUT),
	.ANALOG_WAKE    (ANALOG_WAKE),
	.OSC_RUN        (OSC_RUN),
	.ACQUIRE        (ACQUIRE),
	.SAMPLE         (SAMPLE),
	.DSP_MODE       (DSP_MODE)
);

// >>> testbench/host_model.sv
/*
 Host serial master: select, serial clock, data and frame sync.
 Assumes CLK at 50 ns; the serial clock is eight CLK, idle low.
*/
`timescale 1ns/1ns
module host_model (
	// Clock
	input  wire logic clk,
	// Host pins
	input  wire logic dout,
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	output logic      fs_in,
	output logic      wws
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
		fs_in = 1'b1;
		wws = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic sel(input logic fs, input logic wide);
		wt(1);
		fs_in = fs;
		wws = wide;
		wt(2);
		cs_n = 1'b0;
		wt(4);
	endtask

	task automatic desel();
		wt(1);
		cs_n = 1'b1;
		wt(4);
	endtask

	task automatic fs_strobe();
		wt(1);
		fs_in = 1'b1;
		wt(4);
		fs_in = 1'b0;
		wt(4);
	endtask

	// Low half then high half; read just before the edge that does not move dout
	task automatic bit_clk(input logic d, input logic dsp, output logic q);
		wt(1);
		din = d;
		wt(3);
		if (!dsp) q = dout;
		sclk = 1'b1;
		wt(4);
		if (dsp) q = dout;
		sclk = 1'b0;
	endtask
endmodule

// >>> testbench/adc_serial_conversion_sequencer_tb_top.sv
/*
 Self-checking bench for conv_sequencer with host model and a
 comparator that resolves to a fixed level per channel.
 Assumes the 20 MHz CLK and the default oscillator divider.
*/
`timescale 1ns/1ns
module adc_serial_conversion_sequencer_tb_top;
	import adc_seq_pkg::*;
	typedef struct {
		logic       wide;
		logic [2:0] ch;
		logic [1:0] scan;
		logic [1:0] pd;
		int         n_res;
		logic [2:0] first;
	} row_s;
	row_s rows [4] = '{'{1'b0, 3'h5, 2'h0, 2'h1, 1, 3'h5}, '{1'b1, 3'h2, 2'h1, 2'h2, 3, 3'h0},
		'{1'b0, 3'h3, 2'h2, 2'h3, 2, 3'h2}, '{1'b0, 3'h1, 2'h3, 2'h0, 4, 3'h1}};
	logic        clk, rst_n, cs_n, sclk, din, fs_in, wws, dout, dout_oe, eoc_n, fs_out;
	logic        cmp_high, wake, osc_run, acquire, sample, dsp_mode, q;
	logic [2:0]  channel;
	logic [15:0] sar_trial;
	logic [1:0]  pd_mode;
	int          errors, total_checks, osc_n, acq_n, smp_n;

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	conv_sequencer i_dut (.CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .FRAME_SYNC_IN(fs_in),
		.WORD_WIDTH_SELECT(wws), .DOUT(dout), .DOUT_OE(dout_oe), .EOC_N(eoc_n), .FRAME_SYNC_OUT(fs_out),
		.CMP_HIGH(cmp_high), .ANALOG_WAKE(wake), .OSC_RUN(osc_run), .CHANNEL(channel), .ACQUIRE(acquire),
		.SAMPLE(sample), .SAR_TRIAL(sar_trial), .PD_MODE(pd_mode), .DSP_MODE(dsp_mode));
	// Released line reads as the inverse of its last level
	host_model i_host (.clk(clk), .dout(dout_oe ? dout : ~dout), .cs_n(cs_n), .sclk(sclk), .din(din),
		.fs_in(fs_in), .wws(wws));

	function automatic logic [15:0] level(input logic [2:0] c);
		return 16'h1357 + 16'({13'h0, c} * 16'h2222);
	endfunction

	// Comparator keeps a trial at or below the channel level
	always @(negedge clk) cmp_high <= (sar_trial <= level(channel));

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic wait_eoc();
		int i;
		osc_n = 0;
		acq_n = 0;
		smp_n = 0;
		for (i = 0; i < 4000 && eoc_n !== 1'b0; i++) begin
			@(negedge clk);
			if (osc_run === 1'b1) osc_n++;
			if (acquire === 1'b1) acq_n++;
			if (sample === 1'b1) smp_n++;
		end
		if (eoc_n !== 1'b0) begin
			errors++;
			$display("[FAIL] eoc_wait expected 0 seen %b", eoc_n);
			summarize();
		end
	endtask

	task automatic xact(input row_s r);
		logic [7:0]  cmd;
		logic [15:0] w;
		int          k, nb, tot, ae;
		cmd = {r.ch, r.scan, r.pd, 1'b1};
		nb = r.wide ? CMD_EDGES_16 : CMD_EDGES_8;
		tot = r.wide ? OSC_TOTAL_16 : OSC_TOTAL_8;
		ae = r.wide ? ACQ_END_OSC_16 : ACQ_END_OSC_8;
		i_host.sel(1'b1, r.wide);
		chk("select", 16'h5, 16'({dout_oe, dout, wake}));
		for (k = 0; k < nb; k++) begin
			i_host.bit_clk(k < 8 ? cmd[7 - k] : 1'b0, 1'b0, q);
			if (k == 2) chk("channel", 16'(r.ch), 16'(channel));
			chk("osc_idle", 16'h0, 16'(osc_run));
		end
		i_host.wt(4);
		chk("osc_start", 16'h1, 16'(osc_run));
		wait_eoc();
		chk("osc_cycles", 16'h1, 16'(osc_n >= r.n_res * tot * OSC_DIV_DEF - OSC_DIV_DEF
			&& osc_n <= r.n_res * (tot + 3) * OSC_DIV_DEF));
		chk("acq_cycles", 16'h1, 16'(acq_n >= r.n_res * ((ae - 2) * OSC_DIV_DEF + 1)
			&& acq_n <= r.n_res * (ae - 1) * OSC_DIV_DEF));
		chk("samples", 16'(r.n_res), 16'(smp_n));
		chk("shutdown", 16'h0, 16'({osc_run, wake}));
		for (k = 0; k < 16 * (r.n_res + 1); k++) begin
			i_host.bit_clk(1'b0, 1'b0, q);
			w = {w[14:0], q};
			if (k % 16 == 15) chk("result", level(r.first + ((r.scan == 2'h1 || r.scan == 2'h2) ?
				3'((k / 16) % r.n_res) : 3'h0)), w);
		end
		i_host.desel();
		chk("release", 16'({2'b01, r.pd}), 16'({dout_oe, eoc_n, pd_mode}));
	endtask

	task automatic frame(input logic [2:0] ch, input int stop);
		logic [7:0]  cmd;
		logic [15:0] w;
		int          k;
		cmd = {ch, 5'h01};
		i_host.fs_strobe();
		for (k = 1; k <= stop; k++) begin
			i_host.bit_clk(k <= 8 ? cmd[8 - k] : 1'b0, 1'b1, q);
			if (k == 5) chk("dsp_channel", 16'(ch), 16'(channel));
			if (k == 8) chk("fs_out", 16'h1, 16'(fs_out));
			if (k >= 9) w = {w[14:0], q};
			if (k == 24) chk("dsp_result", level(ch), w);
			if (k > 24) chk("dsp_zero", 16'h0, 16'(q));
		end
	endtask

	initial begin
		errors = 0;
		total_checks = 0;
		rst_n = 1'b0;
		cmp_high = 1'b0;
		repeat (12) @(negedge clk);
		chk("reset_out", 16'h0100, 16'({dout_oe, eoc_n, fs_out, wake, osc_run, acquire, sample, dsp_mode, pd_mode}));
		chk("reset_sar", 16'h0, sar_trial);
		rst_n = 1'b1;
		$display("test reset done");
		foreach (rows[i]) begin
			xact(rows[i]);
			$display("test row %0d done", i);
		end
		i_host.sel(1'b1, 1'b0);
		repeat (8) i_host.bit_clk(1'b0, 1'b0, q);
		i_host.wt(20);
		chk("abort_run", 16'h1, 16'(osc_run));
		i_host.desel();
		chk("abort", 16'h2, 16'({osc_run, wake, eoc_n, dout_oe}));
		xact(rows[0]);
		$display("test abort done");
		i_host.sel(1'b0, 1'b0);
		chk("dsp_mode", 16'h1, 16'(dsp_mode));
		frame(3'h6, 28);
		frame(3'h4, 4);
		frame(3'h1, 24);
		i_host.desel();
		chk("dsp_abort", 16'h0, 16'({dout_oe, wake}));
		$display("test frame mode done");
		summarize();
	end
endmodule
